// File: hw/clrx_regs.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the package and the core module
`ifndef CLRX_REGS_SVH
`define CLRX_REGS_SVH

// register byte offsets on the axi4-lite slave
`define OFS_INSTR 8'h00
`define OFS_CTRL 8'h04
`define OFS_INDEX 8'h08
`define OFS_STATUS 8'h0c
`define OFS_WDOG 8'h10
`define OFS_FADDR 8'h14
`define OFS_FDATA 8'h18
`define OFS_TARGET 8'h1c

// control fields
`define CTRL_EXT_BIT 0
`define CTRL_WDEN_BIT 1
`define CTRL_BANK_LSB 8
`define CTRL_BANK_MSB 11

// status fields
`define ST_ZERO_BIT 0
`define ST_SLEEP_BIT 1
`define ST_EXPIRY_BIT 2
`define ST_BUSY_BIT 3

// watchdog readback: counter low, postscaler from this bit up
`define WDOG_POST_LSB 8

// instruction patterns
`define FILE_CLEAR_OPCODE 7'h35
`define WDOG_CLEAR_WORD 16'h0004

// addressing
`define IDX_LIMIT 8'h5f
`define ACC_HIGH_BIT 7
`define BANK_LOW 4'h0
`define BANK_SFR 4'hf
`define CLEARED_BYTE 8'h00

// reset values
`define CTRL_RST 32'h0000_0002
`define INDEX_RST 12'h000

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

// clock and the one-cycle instruction
`define CLK_PERIOD_NS 100
`define QPHASES 4
`define INSTR_CYCLE_NS 400
`define INSTR_CYCLE_CLKS (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)

`endif

// File: hw/clrx_pkg.sv
// types shared by the clear-instruction core
// assumes clrx_regs.svh on the include path
package clrx_pkg;
    `include "clrx_regs.svh"

    // four-phase instruction cycle, gray along q1..q4
    typedef enum logic [1:0] {
        Q1 = 2'h0,
        Q2 = 2'h1,
        Q3 = 2'h3,
        Q4 = 2'h2
    } qphase_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_CLEAR_FILE = 2'h1,
        OP_WDOG_CLEAR = 2'h2
    } op_t;
endpackage

// File: hw/clear_file_and_watchdog_exec.sv
// decode and execution of the file-clear and watchdog-clear instructions,
// with a banked data memory and the watchdog counter, behind axi4-lite
// assumes one clock (ref_clk) for core and bus; no other clock domain
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "clrx_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1 - file-clear is 0110 101a ffff ffff: bit 8 bank selector, low byte address
// RL2 - file-clear writes 00h to the target, sets zero flag, other flags untouched
// RL3 - selector zero: address falls in the shared access bank
// RL4 - selector one: bank comes from the bank select register
// RL5 - selector zero, extended set on, address <= 5Fh: indexed literal offset
// RL6 - file-clear: one word, one cycle; decode, read, process, write-back in Q1-Q4
// RL7 - watchdog-clear is the fixed word 0000 0000 0000 0100
// RL8 - watchdog-clear zeroes the watchdog counter and its postscaler
// RL9 - watchdog-clear sets expiry and sleep-entry flags, nothing else
// RL10 - watchdog-clear: one cycle; decode Q1, no-op Q2 and Q4, process Q3
// RL11 - after a clear the watchdog counts from zero; expiry needs a full period
module clear_file_and_watchdog_exec
    import clrx_pkg::*;
#(
    parameter int WCNT_W = 8,
    parameter int POST_W = 7,
    parameter logic [POST_W-1:0] POST_LAST = 7'h7f,
    parameter int BANK_W = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // watchdog expiry, one ref_clk cycle
    output logic watchdog_timeout
);

    localparam int AW = BANK_W + 8;

    ////////////////////////////////////////////////////////////////////////
    // state
    qphase_t q_phase_q;
    op_t exec_q;
    logic pend_q;
    logic [15:0] instr_q;
    logic [AW-1:0] target_q;
    logic [7:0] rd_val_q;
    logic [31:0] ctrl_q;
    logic [AW-1:0] index_q;
    logic [AW-1:0] faddr_q;
    logic zero_q;
    logic expiry_flag_n_q;
    logic sleep_entry_flag_n_q;
    logic [WCNT_W-1:0] watchdog_counter_q;
    logic [POST_W-1:0] post_q;
    logic timeout_q;
    logic [7:0] general_purpose_file [0:(1<<AW)-1];

    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    logic ext_en, wdog_en, busy, do_write, wr_instr, wr_status;
    logic [BANK_W-1:0] bank_select_reg;
    logic [31:0] rd_word;
    logic [1:0] rd_resp, wr_resp;

    assign ext_en = ctrl_q[`CTRL_EXT_BIT];
    assign wdog_en = ctrl_q[`CTRL_WDEN_BIT];
    assign bank_select_reg = ctrl_q[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
    assign busy = pend_q | (exec_q != OP_NONE);

    ////////////////////////////////////////////////////////////////////////
    // decoding functions
    function automatic op_t decode_op(input logic [15:0] w);
        op_t op;
        op = OP_NONE;
        if (w[15:9] == `FILE_CLEAR_OPCODE) begin
            op = OP_CLEAR_FILE; // RL1
        end else if (w == `WDOG_CLEAR_WORD) begin
            op = OP_WDOG_CLEAR; // RL7
        end
        return op;
    endfunction

    function automatic logic [AW-1:0] eff_addr(
        input logic a,
        input logic [7:0] f,
        input logic ext,
        input logic [BANK_W-1:0] bank,
        input logic [AW-1:0] base
    );
        logic [AW-1:0] r;
        r = {bank, f};
        if (!a && ext && (f <= `IDX_LIMIT)) begin
            r = base + {{BANK_W{1'b0}}, f}; // RL5
        end else if (!a) begin
            // low half is bank zero, high half the special-function bank
            r = f[`ACC_HIGH_BIT] ? {BANK_W'(`BANK_SFR), f} : {BANK_W'(`BANK_LOW), f}; // RL3
        end
        return r; // RL4
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // four-phase sequencer, free running
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_phase_q <= Q1;
        end else begin
            case (q_phase_q)
                Q1: q_phase_q <= Q2;
                Q2: q_phase_q <= Q3;
                Q3: q_phase_q <= Q4;
                Q4: q_phase_q <= Q1;
                default: q_phase_q <= Q1;
            endcase
        end
    end

    // a written word waits for the next q1, then occupies exactly one cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            instr_q <= 16'h0000;
            exec_q <= OP_NONE;
            target_q <= '0;
        end else begin
            if (wr_instr) begin
                pend_q <= 1'b1;
                instr_q <= wdata_q[15:0];
            end else if (q_phase_q == Q1 && pend_q) begin
                pend_q <= 1'b0;
                exec_q <= decode_op(instr_q); // RL6
                target_q <= eff_addr(instr_q[8], instr_q[7:0], ext_en,
                    bank_select_reg, index_q);
            end else if (q_phase_q == Q4) begin
                exec_q <= OP_NONE;
            end
        end
    end

    // file memory: q2 read, q4 write-back of the cleared byte
    always_ff @(posedge ref_clk) begin
        if (q_phase_q == Q2 && exec_q == OP_CLEAR_FILE) begin
            rd_val_q <= general_purpose_file[target_q]; // RL6
        end
        if (q_phase_q == Q4 && exec_q == OP_CLEAR_FILE) begin
            general_purpose_file[target_q] <= `CLEARED_BYTE; // RL2
        end else if (do_write && awaddr_q == `OFS_FDATA && wr_resp == `RESP_OKAY
            && wstrb_q[0]) begin
            general_purpose_file[faddr_q] <= wdata_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags; instruction effects win over a software write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_q <= 1'b0;
            expiry_flag_n_q <= 1'b1;
            sleep_entry_flag_n_q <= 1'b1;
        end else begin
            if (wr_status) begin
                zero_q <= wdata_q[`ST_ZERO_BIT];
                sleep_entry_flag_n_q <= wdata_q[`ST_SLEEP_BIT];
                expiry_flag_n_q <= wdata_q[`ST_EXPIRY_BIT];
            end
            if (q_phase_q == Q4 && exec_q == OP_CLEAR_FILE) begin
                zero_q <= 1'b1; // RL2
            end
            if (q_phase_q == Q3 && exec_q == OP_WDOG_CLEAR) begin
                expiry_flag_n_q <= 1'b1; // RL9
                sleep_entry_flag_n_q <= 1'b1; // RL9
            end else if (timeout_q) begin
                expiry_flag_n_q <= 1'b0;
            end
        end
    end

    // watchdog ticks once per instruction cycle, at q4
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_counter_q <= '0;
            post_q <= '0;
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= 1'b0;
            if (q_phase_q == Q3 && exec_q == OP_WDOG_CLEAR) begin // RL10
                watchdog_counter_q <= '0; // RL8
                post_q <= '0; // RL8
            end else if (q_phase_q == Q4 && wdog_en) begin
                watchdog_counter_q <= watchdog_counter_q + 1'b1; // RL11
                if (&watchdog_counter_q) begin
                    post_q <= (post_q == POST_LAST) ? '0 : post_q + 1'b1;
                    timeout_q <= (post_q == POST_LAST); // RL11
                end
            end
        end
    end

    assign watchdog_timeout = timeout_q;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_comb begin
        wr_resp = `RESP_OKAY;
        case (awaddr_q)
            `OFS_INSTR, `OFS_FDATA: wr_resp = busy ? `RESP_SLVERR : `RESP_OKAY;
            `OFS_CTRL, `OFS_INDEX, `OFS_STATUS, `OFS_FADDR: wr_resp = `RESP_OKAY;
            `OFS_WDOG, `OFS_TARGET: wr_resp = `RESP_SLVERR;
            default: wr_resp = `RESP_DECERR;
        endcase
    end

    // an instruction or memory write while one is in flight is refused
    assign wr_instr = do_write && awaddr_q == `OFS_INSTR && wr_resp == `RESP_OKAY;
    assign wr_status = do_write && awaddr_q == `OFS_STATUS;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_resp;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // writable configuration
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RST;
            index_q <= AW'(`INDEX_RST);
            faddr_q <= '0;
        end else if (do_write) begin
            case (awaddr_q)
                `OFS_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
                `OFS_INDEX: index_q <= AW'(merge(32'(index_q), wdata_q, wstrb_q));
                `OFS_FADDR: faddr_q <= AW'(merge(32'(faddr_q), wdata_q, wstrb_q));
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read path, one cycle from address to data
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_INSTR: rd_word = {16'h0000, instr_q};
            `OFS_CTRL: rd_word = ctrl_q;
            `OFS_INDEX: rd_word = 32'(index_q);
            `OFS_STATUS: begin
                rd_word[`ST_ZERO_BIT] = zero_q;
                rd_word[`ST_SLEEP_BIT] = sleep_entry_flag_n_q;
                rd_word[`ST_EXPIRY_BIT] = expiry_flag_n_q;
                rd_word[`ST_BUSY_BIT] = busy;
            end
            `OFS_WDOG: begin
                rd_word[WCNT_W-1:0] = watchdog_counter_q;
                rd_word[`WDOG_POST_LSB +: POST_W] = post_q;
            end
            `OFS_FADDR: rd_word = 32'(faddr_q);
            `OFS_FDATA: rd_word = {24'h00_0000, general_purpose_file[faddr_q]};
            `OFS_TARGET: rd_word = 32'(target_q);
            default: rd_resp = `RESP_DECERR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_decoded(op_t op);
        q_phase_q == Q1 && pend_q && decode_op(instr_q) == op;
    endsequence

    sequence s_clear_cycle;
        exec_q == OP_CLEAR_FILE && q_phase_q == Q2
        ##1 exec_q == OP_CLEAR_FILE && q_phase_q == Q3
        ##1 exec_q == OP_CLEAR_FILE && q_phase_q == Q4;
    endsequence

    a_clear_decode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL1
        q_phase_q == Q1 && pend_q && instr_q[15:9] == `FILE_CLEAR_OPCODE
        |=> exec_q == OP_CLEAR_FILE)
        else $error("file-clear pattern not decoded");

    a_clear_readback: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
        q_phase_q == Q3 && exec_q == OP_CLEAR_FILE
        |-> rd_val_q == general_purpose_file[target_q])
        else $error("file-clear target not read in q2");

    a_clear_result: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
        q_phase_q == Q4 && exec_q == OP_CLEAR_FILE
        |=> zero_q && general_purpose_file[$past(target_q)] == `CLEARED_BYTE)
        else $error("file-clear did not zero target and set zero flag");

    a_clear_others: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
        exec_q == OP_CLEAR_FILE && !wr_status && !timeout_q
        |=> $stable(expiry_flag_n_q) && $stable(sleep_entry_flag_n_q))
        else $error("file-clear changed another flag");

    a_access_bank: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
        s_decoded(OP_CLEAR_FILE) ##0 (!instr_q[8] && !(ext_en && instr_q[7:0] <= `IDX_LIMIT))
        |=> target_q[AW-1:8] == (target_q[7] ? BANK_W'(`BANK_SFR) : BANK_W'(`BANK_LOW)))
        else $error("access bank not used");

    a_bank_select: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
        s_decoded(OP_CLEAR_FILE) ##0 instr_q[8]
        |=> target_q == {$past(bank_select_reg), $past(instr_q[7:0])})
        else $error("bank select register not used");

    a_indexed_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
        s_decoded(OP_CLEAR_FILE) ##0 (!instr_q[8] && ext_en && instr_q[7:0] <= `IDX_LIMIT)
        |=> target_q == AW'($past(index_q) + $past(instr_q[7:0])))
        else $error("indexed literal offset address wrong");

    a_clear_phases: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
        s_decoded(OP_CLEAR_FILE) |=> s_clear_cycle ##1 exec_q == OP_NONE)
        else $error("file-clear did not span one instruction cycle");

    a_wdog_decode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
        q_phase_q == Q1 && pend_q && instr_q == `WDOG_CLEAR_WORD
        |=> exec_q == OP_WDOG_CLEAR)
        else $error("watchdog-clear word not decoded");

    a_wdog_zeroed: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL8
        s_decoded(OP_WDOG_CLEAR) |=> ##2 watchdog_counter_q == '0 && post_q == '0)
        else $error("watchdog counter or postscaler not cleared");

    a_wdog_flags: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
        s_decoded(OP_WDOG_CLEAR) |=> ##2 expiry_flag_n_q && sleep_entry_flag_n_q
        && $stable(zero_q))
        else $error("watchdog-clear flags wrong");

    a_wdog_phases: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
        s_decoded(OP_WDOG_CLEAR) |=> $stable(watchdog_counter_q) ##1 1'b1
        ##1 (watchdog_counter_q == '0) ##1 exec_q == OP_NONE)
        else $error("watchdog-clear not processed in q3");

    a_wdog_resume: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
        q_phase_q == Q3 && exec_q == OP_WDOG_CLEAR |=> !timeout_q [*8])
        else $error("watchdog expired right after a clear");

endmodule // clear_file_and_watchdog_exec

`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the file-clear and watchdog-clear core
// assumes clrx_regs.svh on the include path; drives the axi4-lite slave directly
`timescale 1ns/10ps
`default_nettype none
`include "clrx_regs.svh"

`define check_eq(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end

module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic watchdog_timeout;
    int bad_count = 0;
    int samples_checked = 0;

    // shortened watchdog: 16 counts times 4 postscaler steps
    clear_file_and_watchdog_exec #(
        .WCNT_W(4),
        .POST_W(2),
        .POST_LAST(2'h3),
        .BANK_W(4)
    ) dut_u (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .watchdog_timeout(watchdog_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input int n);
        if (n >= 60) begin
            bad_count++;
            $display("unexpected at %0t: wait ran out", $time);
            tally_and_finish();
        end
    endtask

    // write address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 60);
        hang(n);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 60);
        hang(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        `check_eq(r, `RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        `check_eq(d, e)
        `check_eq(r, `RESP_OKAY)
    endtask

    // issue one instruction word and poll busy; a single-cycle op needs few polls
    task automatic run_op(input logic [15:0] w);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr_ok(`OFS_INSTR, {16'h0000, w});
        n = 0;
        do begin
            axi_rd(`OFS_STATUS, d, r);
            n++;
        end while (d[`ST_BUSY_BIT] !== 1'b0 && n < 60);
        hang(n);
        `check_eq(n <= 4, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic reset_values();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(`OFS_CTRL, 32'h0000_0002);
        rd_chk(`OFS_STATUS, 32'h0000_0006);
        rd_chk(`OFS_INDEX, 32'h0000_0000);
        axi_rd(8'h20, d, r);
        `check_eq(r, `RESP_DECERR)
        `check_eq(d, 32'h0000_0000)
        axi_wr(`OFS_WDOG, 32'h0000_0000, r);
        `check_eq(r, `RESP_SLVERR)
        axi_wr(8'h20, 32'h0000_0000, r);
        `check_eq(r, `RESP_DECERR)
    endtask

    // watchdog kept off here so no expiry disturbs the flag checks
    task automatic file_case(input logic [31:0] ctrl, input logic [15:0] w,
            input logic [11:0] addr, input logic hit);
        wr_ok(`OFS_CTRL, ctrl);
        rd_chk(`OFS_CTRL, ctrl);
        wr_ok(`OFS_INDEX, 32'h0000_0123);
        wr_ok(`OFS_FADDR, {20'h00000, addr});
        wr_ok(`OFS_FDATA, 32'h0000_00a5);
        wr_ok(`OFS_STATUS, 32'h0000_0006);
        run_op(w);
        rd_chk(`OFS_FDATA, hit ? 32'h0000_0000 : 32'h0000_00a5);
        rd_chk(`OFS_STATUS, hit ? 32'h0000_0007 : 32'h0000_0006);
        if (hit) rd_chk(`OFS_TARGET, {20'h00000, addr});
    endtask

    task automatic watchdog_clear();
        logic [31:0] d;
        logic [1:0] r;
        wr_ok(`OFS_CTRL, 32'h0000_0000);
        wr_ok(`OFS_STATUS, 32'h0000_0000);
        axi_rd(`OFS_WDOG, d, r);
        `check_eq(d != 32'h0000_0000, 1'b1)
        // a second word while the first is still in flight must be refused
        axi_wr(`OFS_INSTR, 32'h0000_0005, r);
        `check_eq(r, `RESP_OKAY)
        axi_wr(`OFS_INSTR, 32'h0000_0004, r);
        `check_eq(r, `RESP_SLVERR)
        run_op(16'h0005);
        rd_chk(`OFS_STATUS, 32'h0000_0000);
        run_op(16'h0004);
        rd_chk(`OFS_STATUS, 32'h0000_0006);
        rd_chk(`OFS_WDOG, 32'h0000_0000);
    endtask

    // 64 counts of 4 clocks from the clear, less the polling delay
    task automatic watchdog_period();
        int n;
        wr_ok(`OFS_CTRL, 32'h0000_0002);
        run_op(16'h0004);
        n = 0;
        while (watchdog_timeout !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400) hang(60);
        `check_eq(n >= 240 && n <= 262, 1'b1)
        @(posedge ref_clk);
        `check_eq(watchdog_timeout, 1'b0)
        rd_chk(`OFS_STATUS, 32'h0000_0002);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        reset_values();
        file_case(32'h0000_0300, 16'h6b5a, 12'h35a, 1'b1);
        file_case(32'h0000_0300, 16'h6a20, 12'h020, 1'b1);
        file_case(32'h0000_0300, 16'h6a90, 12'hf90, 1'b1);
        file_case(32'h0000_0301, 16'h6a5f, 12'h182, 1'b1);
        file_case(32'h0000_0301, 16'h6a60, 12'h060, 1'b1);
        file_case(32'h0000_0301, 16'h6b10, 12'h310, 1'b1);
        file_case(32'h0000_0300, 16'h6c5a, 12'h35a, 1'b0);
        watchdog_clear();
        watchdog_period();
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
